// *** hw/mirror_redirect.sv ***
// Mirror selection and CPU redirect decision stage of the forwarding pipeline
`timescale 1ns/1ns
`default_nettype none
module mirror_redirect
  import mirror_redirect_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              frame_valid,
  input  wire frame_in_s         frame_in,
  output logic                   frame_ready,
  output logic                   out_valid,
  output frame_out_s             frame_out
);

  logic [DATA_W-1:0]  port_cfg_r;
  logic [PMASK_W-1:0] egr_mirror_r;
  logic [PMASK_W-1:0] mirror_ports_r;
  logic [QUEUE_W-1:0] q_mirror_r;
  logic [QUEUE_W-1:0] q_ipv4_r;
  logic [QUEUE_W-1:0] q_ipv6_r;
  logic [QUEUE_W-1:0] q_slow_r;
  logic               cpu_mirror_r;
  logic               learn_mirror_r;
  logic [VID_W-1:0]   vlan_index_r;
  logic [15:0]        mirror_count_r;
  logic [15:0]        redirect_count_r;
  logic               last_mirrored_r;
  logic               last_redirected_r;

  stage_e             state_r;
  stage_e             state_nxt;
  frame_in_s          hold_r;
  logic               vlan_flag;
  logic               vlan_rd_flag;
  logic               mem_we;
  logic [VID_W-1:0]   lookup_vid;

  // Frame stage: one frame in flight; the VLAN flag is fetched on the take edge
  assign frame_ready = (state_r == ST_IDLE);

  always_comb begin
    case (state_r)
      ST_IDLE:   state_nxt = frame_valid ? ST_LOOKUP : ST_IDLE;
      ST_LOOKUP: state_nxt = ST_ISSUE;
      ST_ISSUE:  state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The taken frame is held so the source may move on while the lookup runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_r <= '0;
    end else if (frame_valid && frame_ready) begin
      hold_r <= frame_in;
    end
  end

  assign mem_we = reg_wr && (reg_addr == REG_FLAG_A);

  // Reading the held VID would give the flag one frame late: the memory output is registered
  assign lookup_vid = frame_ready ? frame_in.vid : hold_r.vid;

  vlan_flag_mem #(
    .DEPTH (NUM_VLANS),
    .AW    (VID_W)
  ) i_vlan_flag_mem (
    .clk     (clk),
    .we      (mem_we),
    .waddr   (vlan_index_r),
    .wdata   (reg_wdata[0]),
    .raddr_a (lookup_vid),
    .rdata_a (vlan_flag),
    .raddr_b (vlan_index_r),
    .rdata_b (vlan_rd_flag)
  );

  // Decision logic
  logic [NUM_PORTS-1:0] ingress_en;
  logic [NUM_PORTS-1:0] slow_en;
  logic [NUM_PORTS-1:0] ipv4_en;
  logic [NUM_PORTS-1:0] ipv6_en;
  logic                 slow_hit;
  logic                 ipv4_hit;
  logic                 ipv6_hit;
  logic                 redirect;
  logic [PMASK_W-1:0]   fwd_dest;
  logic                 fwd_cpu;
  logic [QUEUE_W-1:0]   fwd_queue;
  logic                 mirror_hit;
  logic                 egress_hit;

  assign ingress_en = port_cfg_r[PCFG_INGRESS_LSB +: NUM_PORTS];
  assign slow_en    = port_cfg_r[PCFG_SLOW_LSB +: NUM_PORTS];
  assign ipv4_en    = port_cfg_r[PCFG_IPV4_LSB +: NUM_PORTS];
  assign ipv6_en    = port_cfg_r[PCFG_IPV6_LSB +: NUM_PORTS];

  assign slow_hit = slow_en[hold_r.src_port] && (hold_r.dmac == SLOW_PROTO_DMAC);
  assign ipv4_hit = ipv4_en[hold_r.src_port] && hold_r.is_ipv4_group;
  assign ipv6_hit = ipv6_en[hold_r.src_port] && hold_r.is_ipv6_listener;
  assign redirect = slow_hit || ipv4_hit || ipv6_hit;

  // Redirect replaces normal forwarding by the CPU alone, each kind with its own queue
  always_comb begin
    fwd_dest  = hold_r.dest;
    fwd_cpu   = hold_r.to_cpu;
    fwd_queue = hold_r.cpu_queue;
    if (slow_hit) begin
      fwd_dest  = '0;
      fwd_cpu   = 1'b1;
      fwd_queue = q_slow_r;
    end else if (ipv4_hit) begin
      fwd_dest  = '0;
      fwd_cpu   = 1'b1;
      fwd_queue = q_ipv4_r;
    end else if (ipv6_hit) begin
      fwd_dest  = '0;
      fwd_cpu   = 1'b1;
      fwd_queue = q_ipv6_r;
    end
  end

  // Egress mirroring judges the final destination set, after any redirect
  assign egress_hit = |(fwd_dest & egr_mirror_r);

  // All triggers are ORed so any mix may be active toward one mirror set
  assign mirror_hit = ingress_en[hold_r.src_port]
                   || egress_hit
                   || vlan_flag
                   || (cpu_mirror_r && fwd_cpu)
                   || (learn_mirror_r && hold_r.learn)
                   || hold_r.cls_mirror;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else begin
      out_valid <= (state_r == ST_LOOKUP);
    end
  end

  // Result fields hold until the next frame, so a slow consumer may still read them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_out <= '0;
    end else begin
      if (state_r == ST_LOOKUP) begin
        frame_out.dest          <= fwd_dest;
        frame_out.to_cpu        <= fwd_cpu;
        frame_out.cpu_queue     <= fwd_queue;
        frame_out.mirror_dest   <= mirror_hit ? mirror_ports_r : '0;
        frame_out.mirror_to_cpu <= mirror_hit && mirror_ports_r[CPU_PORT];
        frame_out.mirror_queue  <= q_mirror_r;
        frame_out.redirected    <= redirect;
      end
    end
  end

  // Statistics; the counters wrap without notice, so software must poll them often enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mirror_count_r <= '0;
    end else if (state_r == ST_LOOKUP) begin
      mirror_count_r <= mirror_count_r + 16'(mirror_hit);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      redirect_count_r <= '0;
    end else if (state_r == ST_LOOKUP) begin
      redirect_count_r <= redirect_count_r + 16'(redirect);
    end
  end

  // Last-frame status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_mirrored_r   <= 1'b0;
      last_redirected_r <= 1'b0;
    end else if (state_r == ST_LOOKUP) begin
      last_mirrored_r   <= mirror_hit;
      last_redirected_r <= redirect;
    end
  end

  // Register writes: one decoded strobe per register; unmapped and read-only addresses are ignored
  logic wr_port_cfg;
  logic wr_egr_mirror;
  logic wr_mirror_ports;
  logic wr_cpu_queues;
  logic wr_global_ctrl;
  logic wr_vlan_index;

  assign wr_port_cfg     = reg_wr && (reg_addr == REG_PORT_CFG);
  assign wr_egr_mirror   = reg_wr && (reg_addr == REG_EGR_MIRROR);
  assign wr_mirror_ports = reg_wr && (reg_addr == REG_MIRROR_PORTS);
  assign wr_cpu_queues   = reg_wr && (reg_addr == REG_CPU_QUEUES);
  assign wr_global_ctrl  = reg_wr && (reg_addr == REG_GLOBAL_CTRL);
  assign wr_vlan_index   = reg_wr && (reg_addr == REG_VLAN_INDEX);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_cfg_r <= RESET_WORD;
    end else if (wr_port_cfg) begin
      port_cfg_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      egr_mirror_r <= '0;
    end else if (wr_egr_mirror) begin
      egr_mirror_r <= reg_wdata[PMASK_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mirror_ports_r <= '0;
    end else if (wr_mirror_ports) begin
      mirror_ports_r <= reg_wdata[PMASK_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_mirror_r <= '0;
      q_ipv4_r   <= '0;
      q_ipv6_r   <= '0;
      q_slow_r   <= '0;
    end else if (wr_cpu_queues) begin
      q_mirror_r <= reg_wdata[CQ_MIRROR_LSB +: QUEUE_W];
      q_ipv4_r   <= reg_wdata[CQ_IPV4_LSB +: QUEUE_W];
      q_ipv6_r   <= reg_wdata[CQ_IPV6_LSB +: QUEUE_W];
      q_slow_r   <= reg_wdata[CQ_SLOW_LSB +: QUEUE_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_mirror_r   <= 1'b0;
      learn_mirror_r <= 1'b0;
    end else if (wr_global_ctrl) begin
      cpu_mirror_r   <= reg_wdata[GC_CPU_MIRROR_BIT];
      learn_mirror_r <= reg_wdata[GC_LEARN_MIRROR_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vlan_index_r <= '0;
    end else if (wr_vlan_index) begin
      vlan_index_r <= reg_wdata[VID_W-1:0];
    end
  end

  // Register reads: data stand in the cycle after the strobe only
  logic [DATA_W-1:0] rd_mux;
  logic              rd_vlan_r;

  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      REG_PORT_CFG:       rd_mux = port_cfg_r;
      REG_EGR_MIRROR:     rd_mux[PMASK_W-1:0] = egr_mirror_r;
      REG_MIRROR_PORTS:   rd_mux[PMASK_W-1:0] = mirror_ports_r;
      REG_CPU_QUEUES: begin
        rd_mux[CQ_MIRROR_LSB +: QUEUE_W] = q_mirror_r;
        rd_mux[CQ_IPV4_LSB +: QUEUE_W]   = q_ipv4_r;
        rd_mux[CQ_IPV6_LSB +: QUEUE_W]   = q_ipv6_r;
        rd_mux[CQ_SLOW_LSB +: QUEUE_W]   = q_slow_r;
      end
      REG_GLOBAL_CTRL: begin
        rd_mux[GC_CPU_MIRROR_BIT]   = cpu_mirror_r;
        rd_mux[GC_LEARN_MIRROR_BIT] = learn_mirror_r;
      end
      REG_VLAN_INDEX:     rd_mux[VID_W-1:0] = vlan_index_r;
      REG_STATUS:         rd_mux[1:0] = {last_redirected_r, last_mirrored_r};
      REG_MIRROR_COUNT:   rd_mux[15:0] = mirror_count_r;
      REG_REDIRECT_COUNT: rd_mux[15:0] = redirect_count_r;
      default:            rd_mux = '0;
    endcase
  end

  logic [DATA_W-1:0] rd_hold_r;
  logic              rd_pend_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pend_r <= 1'b0;
    end else begin
      rd_pend_r <= reg_rd;
    end
  end

  // The VLAN flag comes from the memory's registered port, so it is merged one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_vlan_r <= 1'b0;
    end else begin
      rd_vlan_r <= reg_rd && (reg_addr == REG_FLAG_A);
    end
  end

  // Cleared between reads so stale register contents never leak onto the bus
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_hold_r <= '0;
    end else begin
      rd_hold_r <= reg_rd ? rd_mux : '0;
    end
  end

  always_comb begin
    reg_rdata = '0;
    if (rd_pend_r) begin
      reg_rdata = rd_vlan_r ? {31'h00000000, vlan_rd_flag} : rd_hold_r;
    end
  end

endmodule
`default_nettype wire

// *** hw/mirror_redirect_pkg.sv ***
// Package with constants, register map and carrier structs for the mirror and CPU redirect block
package mirror_redirect_pkg;

  localparam int NUM_PORTS  = 4;
  localparam int CPU_PORT   = NUM_PORTS;
  localparam int PMASK_W    = NUM_PORTS + 1;
  localparam int VID_W      = 12;
  localparam int NUM_VLANS  = 4096;
  localparam int QUEUE_W    = 3;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  localparam logic [47:0] SLOW_PROTO_DMAC = 48'h0180C2000002;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] REG_PORT_CFG       = 8'h00;
  localparam logic [ADDR_W-1:0] REG_EGR_MIRROR     = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MIRROR_PORTS   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CPU_QUEUES     = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_GLOBAL_CTRL    = 8'h10;
  localparam logic [ADDR_W-1:0] REG_VLAN_INDEX     = 8'h14;
  localparam logic [ADDR_W-1:0] REG_FLAG_A    = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS         = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_MIRROR_COUNT   = 8'h20;
  localparam logic [ADDR_W-1:0] REG_REDIRECT_COUNT = 8'h24;

  // Port config fields: four per-port enable groups of NUM_PORTS bits
  localparam int PCFG_INGRESS_LSB = 0;
  localparam int PCFG_SLOW_LSB    = 8;
  localparam int PCFG_IPV4_LSB    = 16;
  localparam int PCFG_IPV6_LSB    = 24;

  // CPU queue fields
  localparam int CQ_MIRROR_LSB = 0;
  localparam int CQ_IPV4_LSB   = 4;
  localparam int CQ_IPV6_LSB   = 8;
  localparam int CQ_SLOW_LSB   = 12;

  // Global control fields
  localparam int GC_CPU_MIRROR_BIT   = 0;
  localparam int GC_LEARN_MIRROR_BIT = 1;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_LOOKUP = 3'b010,
    ST_ISSUE  = 3'b100
  } stage_e;

  typedef struct packed {
    logic [1:0]         src_port;
    logic [47:0]        dmac;
    logic [VID_W-1:0]   vid;
    logic [PMASK_W-1:0] dest;
    logic               to_cpu;
    logic [QUEUE_W-1:0] cpu_queue;
    logic               is_ipv4_group;
    logic               is_ipv6_listener;
    logic               learn;
    logic               cls_mirror;
  } frame_in_s;

  typedef struct packed {
    logic [PMASK_W-1:0] dest;
    logic               to_cpu;
    logic [QUEUE_W-1:0] cpu_queue;
    logic [PMASK_W-1:0] mirror_dest;
    logic               mirror_to_cpu;
    logic [QUEUE_W-1:0] mirror_queue;
    logic               redirected;
  } frame_out_s;

endpackage

// *** hw/vlan_flag_mem.sv ***
// One-bit-per-Flag_a flag memory with registered read
`timescale 1ns/1ns
`default_nettype none
module vlan_flag_mem
  import mirror_redirect_pkg::*;
#(
  parameter int DEPTH = NUM_VLANS,
  parameter int AW    = VID_W
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic          wdata,
  input  wire logic [AW-1:0] raddr_a,
  output logic               rdata_a,
  input  wire logic [AW-1:0] raddr_b,
  output logic               rdata_b
);

  // No reset: software must clear flags it relies on before use
  logic mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end

endmodule
`default_nettype wire

// *** tb/mirror_redirect_checker.sv ***
// Port-level assertions for the mirror and CPU redirect stage
`timescale 1ns/1ns
`default_nettype none
module mirror_redirect_checker
  import mirror_redirect_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              frame_valid,
  input wire frame_in_s         frame_in,
  input wire logic              frame_ready,
  input wire logic              out_valid,
  input wire frame_out_s        frame_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ready_gap: assert property (frame_valid && frame_ready |=> !frame_ready [*2] ##1 frame_ready)
    else $error("ready not low for two cycles after take");
  a_answer_delay: assert property (frame_valid && frame_ready |-> ##1 !out_valid ##1 out_valid ##1 !out_valid)
    else $error("result pulse not two cycles after take");
  a_result_held: assert property (!out_valid |-> $stable(frame_out))
    else $error("result changed without pulse");
  a_redirect_form: assert property (out_valid && frame_out.redirected |-> frame_out.dest == '0 && frame_out.to_cpu)
    else $error("redirected frame still forwarded");
  a_redirect_cause: assert property (out_valid && frame_out.redirected |->
    $past(frame_in.dmac, 2) == SLOW_PROTO_DMAC || $past(frame_in.is_ipv4_group, 2) ||
    $past(frame_in.is_ipv6_listener, 2))
    else $error("redirect without cause");
  a_keep_dest: assert property (out_valid && !frame_out.redirected |->
    frame_out.dest == $past(frame_in.dest, 2) && frame_out.to_cpu == $past(frame_in.to_cpu, 2))
    else $error("mirror changed original destination");
  a_mirror_cpu: assert property (out_valid |-> frame_out.mirror_to_cpu == frame_out.mirror_dest[CPU_PORT])
    else $error("mirror to cpu disagrees with mirror mask");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// *** tb/forward_source.sv ***
// Pipeline-side partner: offers one frame, holds it until taken, captures the result
`timescale 1ns/1ns
`default_nettype none
module forward_source
  import mirror_redirect_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire frame_in_s  req,
  input  wire logic       frame_ready,
  input  wire logic       out_valid,
  input  wire frame_out_s frame_out,
  output logic            frame_valid,
  output frame_in_s       frame_in,
  output logic            done,
  output frame_out_s      got
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_valid <= 1'b0;
      frame_in    <= '0;
      done        <= 1'b0;
      got         <= '0;
    end else begin
      done <= out_valid;
      if (out_valid) got <= frame_out;
      if (start) begin
        frame_valid <= 1'b1;
        frame_in    <= req;
      end else if (frame_valid && frame_ready) begin
        frame_valid <= 1'b0;
        // Stale frame data is inverted so it never looks like a held request
        frame_in    <= ~frame_in;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/mirror_redirect_bench.sv ***
// Register and frame tests for the mirror and CPU redirect stage
`timescale 1ns/1ns
`default_nettype none
module mirror_redirect_bench
  import mirror_redirect_pkg::*;
;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              frame_valid, frame_ready, out_valid, done;
  logic              start = 1'b0;
  frame_in_s         frame_in;
  frame_in_s         req = '0;
  frame_out_s        frame_out, got;
  int                err_total = 0;
  int                total_checks = 0;
  logic [31:0]       mir_cnt = 32'h0;
  logic [31:0]       red_cnt = 32'h0;
  always #10 clk = ~clk;
  mirror_redirect i_mirror_redirect (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid), .frame_in(frame_in),
    .frame_ready(frame_ready), .out_valid(out_valid), .frame_out(frame_out));
  forward_source i_forward_source (.clk(clk), .rst(rst), .start(start), .req(req), .frame_ready(frame_ready),
    .out_valid(out_valid), .frame_out(frame_out), .frame_valid(frame_valid), .frame_in(frame_in),
    .done(done), .got(got));
  task automatic note(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 note("register", e, reg_rdata);
  endtask
  function automatic frame_in_s fi(input logic [1:0] s, input logic sl, input logic [11:0] v,
    input logic [4:0] d, input logic c, input logic [2:0] q, input logic [3:0] fl);
    fi = {s, sl ? SLOW_PROTO_DMAC : 48'h0180C2000003, v, d, c, q, fl};
  endfunction
  function automatic frame_out_s fo(input logic [4:0] d, input logic c, input logic [2:0] q,
    input logic [4:0] md, input logic mc, input logic rd);
    fo = {d, c, q, md, mc, 3'h3, rd};
  endfunction
  task automatic chk_frame(input frame_in_s f, input frame_out_s e, input string n);
    int i;
    @(posedge clk) {start, req} <= {1'b1, f};
    @(posedge clk) start <= 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i++) begin
      @(posedge clk) #1;
    end
    note({n, " answer"}, 32'h1, {31'h0, done});
    note(n, {13'h0, e}, {13'h0, got});
    mir_cnt += (e.mirror_dest != 5'h00);
    red_cnt += e.redirected;
    $display("test %s done", n);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000 err_total++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_reg(REG_PORT_CFG, RESET_WORD);
    chk_reg(REG_MIRROR_PORTS, RESET_WORD);
    wr(REG_PORT_CFG, 32'h08050102);
    wr(REG_EGR_MIRROR, 32'h00000008);
    wr(REG_MIRROR_PORTS, 32'h00000014);
    wr(REG_CPU_QUEUES, 32'h00007653);
    wr(REG_VLAN_INDEX, 32'h5);
    wr(REG_FLAG_A, 32'h1);
    chk_reg(REG_FLAG_A, 32'h1);
    wr(REG_VLAN_INDEX, 32'h6);
    wr(REG_FLAG_A, 32'h0);
    chk_reg(REG_FLAG_A, 32'h0);
    chk_reg(REG_VLAN_INDEX, 32'h6);
    chk_reg(REG_CPU_QUEUES, 32'h00007653);
    wr(8'h40, 32'hFFFFFFFF);
    chk_reg(8'h40, 32'h0);
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'h0), fo(5'h02, 1'b0, 3'h0, 5'h00, 1'b0, 1'b0), "plain");
    chk_frame(fi(2'h0, 1'b1, 12'h6, 5'h02, 1'b0, 3'h0, 4'h0), fo(5'h00, 1'b1, 3'h7, 5'h00, 1'b0, 1'b1), "slow");
    chk_reg(REG_STATUS, 32'h2);
    chk_frame(fi(2'h1, 1'b1, 12'h6, 5'h02, 1'b0, 3'h0, 4'h0), fo(5'h02, 1'b0, 3'h0, 5'h14, 1'b1, 1'b0), "ingr");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'h8), fo(5'h00, 1'b1, 3'h5, 5'h00, 1'b0, 1'b1), "v4");
    chk_frame(fi(2'h3, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'h4), fo(5'h00, 1'b1, 3'h6, 5'h00, 1'b0, 1'b1), "v6");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'h4), fo(5'h02, 1'b0, 3'h0, 5'h00, 1'b0, 1'b0), "v6off");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'hC), fo(5'h00, 1'b1, 3'h5, 5'h00, 1'b0, 1'b1), "both");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h0A, 1'b0, 3'h0, 4'h0), fo(5'h0A, 1'b0, 3'h0, 5'h14, 1'b1, 1'b0), "egr");
    chk_frame(fi(2'h0, 1'b0, 12'h5, 5'h02, 1'b0, 3'h0, 4'h0), fo(5'h02, 1'b0, 3'h0, 5'h14, 1'b1, 1'b0), "vlan");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'h1), fo(5'h02, 1'b0, 3'h0, 5'h14, 1'b1, 1'b0), "cls");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'h2), fo(5'h02, 1'b0, 3'h0, 5'h00, 1'b0, 1'b0), "lrn0");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h00, 1'b1, 3'h2, 4'h0), fo(5'h00, 1'b1, 3'h2, 5'h00, 1'b0, 1'b0), "cpu0");
    wr(REG_GLOBAL_CTRL, 32'h3);
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'h2), fo(5'h02, 1'b0, 3'h0, 5'h14, 1'b1, 1'b0), "lrn1");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h00, 1'b1, 3'h2, 4'h0), fo(5'h00, 1'b1, 3'h2, 5'h14, 1'b1, 1'b0), "cpu1");
    chk_frame(fi(2'h0, 1'b0, 12'h6, 5'h02, 1'b0, 3'h0, 4'h8), fo(5'h00, 1'b1, 3'h5, 5'h14, 1'b1, 1'b1), "rdm");
    wr(REG_MIRROR_PORTS, 32'h1);
    chk_frame(fi(2'h1, 1'b0, 12'h5, 5'h02, 1'b0, 3'h0, 4'h1), fo(5'h02, 1'b0, 3'h0, 5'h01, 1'b0, 1'b0), "multi");
    chk_reg(REG_STATUS, 32'h1);
    wr(REG_MIRROR_COUNT, 32'hFFFFFFFF);
    chk_reg(REG_MIRROR_COUNT, mir_cnt);
    chk_reg(REG_REDIRECT_COUNT, red_cnt);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk_reg(REG_MIRROR_COUNT, RESET_WORD);
    chk_reg(REG_GLOBAL_CTRL, RESET_WORD);
    $display("test reset done");
    print_verdict();
  end
endmodule
bind mirror_redirect mirror_redirect_checker i_mirror_redirect_checker (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
  .frame_in(frame_in), .frame_ready(frame_ready), .out_valid(out_valid), .frame_out(frame_out));
`default_nettype wire
